/* File: design/rcc_regs.svh */
// register offsets, field positions and reset values of the rate converter
// control bank; included by the package and the design files, definitions only
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

`define RCC_ADDR_W        16
`define RCC_OFS_C1_RATE   16'ha400
`define RCC_OFS_C1_PATH   16'ha404
`define RCC_OFS_C2_RATE   16'ha510
`define RCC_OFS_C2_PATH   16'ha514
`define RCC_RATE_HI_MSB   31
`define RCC_RATE_HI_LSB   27
`define RCC_RATE_LO_MSB   15
`define RCC_RATE_LO_LSB   11
`define RCC_UP_LSB        8
`define RCC_DOWN_LSB      0
`define RCC_RATE_W        5
`define RCC_RATE_RST      5'h00
`define RCC_PATH_RST      4'h0
`define RCC_RATE_MAX      5'h03

`endif

/* File: design/rcc_pkg.sv */
// types shared by the rate converter control bank
// assumes rcc_regs.svh gives the field widths
`include "rcc_regs.svh"

package rcc_pkg;

  typedef logic [`RCC_RATE_W-1:0] rcc_rate_t;

  // register decode result
  typedef enum logic [2:0]
  {
    RCC_SEL_NONE    = 3'h0,
    RCC_SEL_C1_RATE = 3'h1,
    RCC_SEL_C1_PATH = 3'h2,
    RCC_SEL_C2_RATE = 3'h3,
    RCC_SEL_C2_PATH = 3'h4
  } rcc_sel_t;

endpackage : rcc_pkg

/* File: design/rcc_conv_ctl.sv */
// one converter's path enable set, with the clock check admission
// assumes writes arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps
`include "rcc_regs.svh"

module rcc_conv_ctl #(
  parameter int NPATH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr,
  input  wire logic [NPATH-1:0] up_wdata,
  input  wire logic [NPATH-1:0] down_wdata,
  input  wire logic             clk_ok,
  output logic      [NPATH-1:0] up_on,
  output logic      [NPATH-1:0] down_on,
  output logic                  refused
);

  logic [NPATH-1:0] up_q;
  logic [NPATH-1:0] up_d;
  logic [NPATH-1:0] down_q;
  logic [NPATH-1:0] down_d;
  logic             ref_q;
  logic             ref_d;

  // refuse path counts that the field layout cannot hold
  if (NPATH < 1 || NPATH > 4)
  begin : g_bad_npath
    $error("rcc_conv_ctl: NPATH must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // new enables only admitted while the clock suffices; old ones can still be cleared
  always_comb
  begin
    up_d   = up_q;
    down_d = down_q;
    ref_d  = 1'b0;  // refusal flag lasts one cycle only
    if (wr)
    begin
      up_d   = clk_ok ? up_wdata : (up_wdata & up_q);
      down_d = clk_ok ? down_wdata : (down_wdata & down_q);
      ref_d  = !clk_ok && (|(up_wdata & ~up_q) ||
                           |(down_wdata & ~down_q));
    end
  end

  // enable state, zero after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      up_q   <= '0;
      down_q <= '0;
      ref_q  <= 1'b0;
    end
    else
    begin
      up_q   <= up_d;
      down_q <= down_d;
      ref_q  <= ref_d;
    end
  end

  assign up_on   = up_q;   // 1 runs the path, 0 holds it off
  assign down_on = down_q;
  assign refused = ref_q;

endmodule : rcc_conv_ctl

/* File: design/rcc_bank.sv */
// control register bank for two synchronous rate converters
// assumes a plain register port on clk; clk_ok from the clock checker
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "rcc_regs.svh"

module rcc_bank #(
  parameter int C1_PATHS = 4,
  parameter int C2_PATHS = 2
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`RCC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   clk_ok,
  output rcc_pkg::rcc_rate_t          conv1_low_rate,
  output rcc_pkg::rcc_rate_t          conv1_high_rate,
  output rcc_pkg::rcc_rate_t          conv2_low_rate,
  output rcc_pkg::rcc_rate_t          conv2_high_rate,
  output logic      [C1_PATHS-1:0]    conv1_up_path_on,
  output logic      [C1_PATHS-1:0]    conv1_down_path_on,
  output logic      [C2_PATHS-1:0]    conv2_up_path_on,
  output logic      [C2_PATHS-1:0]    conv2_down_path_on,
  output logic                        enable_refused
);

  rcc_pkg::rcc_sel_t  sel;
  rcc_pkg::rcc_rate_t c1_lo_q;
  rcc_pkg::rcc_rate_t c1_lo_d;
  rcc_pkg::rcc_rate_t c1_hi_q;
  rcc_pkg::rcc_rate_t c1_hi_d;
  rcc_pkg::rcc_rate_t c2_lo_q;
  rcc_pkg::rcc_rate_t c2_lo_d;
  rcc_pkg::rcc_rate_t c2_hi_q;
  rcc_pkg::rcc_rate_t c2_hi_d;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;
  logic               c1_ref;
  logic               c2_ref;
  logic               wr_c1p;
  logic               wr_c2p;

  // refuse any path counts other than the 4 and 2 that the field layout fixes
  if (C1_PATHS != 4 || C2_PATHS != 2)
  begin : g_bad_paths
    $error("rcc_bank: field layout needs 4 and 2 paths");
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode; anything else is unmapped
  always_comb
  begin
    case (reg_addr)
      `RCC_OFS_C1_RATE: sel = rcc_pkg::RCC_SEL_C1_RATE;
      `RCC_OFS_C1_PATH: sel = rcc_pkg::RCC_SEL_C1_PATH;
      `RCC_OFS_C2_RATE: sel = rcc_pkg::RCC_SEL_C2_RATE;
      `RCC_OFS_C2_PATH: sel = rcc_pkg::RCC_SEL_C2_PATH;
      default:          sel = rcc_pkg::RCC_SEL_NONE;
    endcase
  end

  assign wr_c1p = reg_wr && (sel == rcc_pkg::RCC_SEL_C1_PATH);
  assign wr_c2p = reg_wr && (sel == rcc_pkg::RCC_SEL_C2_PATH);

  ////////////////////////////////////////////////////////////////////////
  // rate select next values; stored as written, field order per converter
  always_comb
  begin
    c1_lo_d = c1_lo_q;
    c1_hi_d = c1_hi_q;
    c2_lo_d = c2_lo_q;
    c2_hi_d = c2_hi_q;
    if (reg_wr && sel == rcc_pkg::RCC_SEL_C1_RATE)
    begin
      c1_lo_d = reg_wdata[`RCC_RATE_HI_MSB:`RCC_RATE_HI_LSB];
      c1_hi_d = reg_wdata[`RCC_RATE_LO_MSB:`RCC_RATE_LO_LSB];
    end
    if (reg_wr && sel == rcc_pkg::RCC_SEL_C2_RATE)
    begin
      c2_hi_d = reg_wdata[`RCC_RATE_HI_MSB:`RCC_RATE_HI_LSB];
      c2_lo_d = reg_wdata[`RCC_RATE_LO_MSB:`RCC_RATE_LO_LSB];
    end
  end

  // rate select registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      c1_lo_q <= `RCC_RATE_RST;
      c1_hi_q <= `RCC_RATE_RST;
      c2_lo_q <= `RCC_RATE_RST;
      c2_hi_q <= `RCC_RATE_RST;
    end
    else
    begin
      c1_lo_q <= c1_lo_d;
      c1_hi_q <= c1_hi_d;
      c2_lo_q <= c2_lo_d;
      c2_hi_q <= c2_hi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // path enables of each converter
  rcc_conv_ctl #(
    .NPATH (C1_PATHS)
  ) u_conv1 (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr         (wr_c1p),
    .up_wdata   (reg_wdata[`RCC_UP_LSB+C1_PATHS-1:`RCC_UP_LSB]),
    .down_wdata (reg_wdata[`RCC_DOWN_LSB+C1_PATHS-1:`RCC_DOWN_LSB]),
    .clk_ok     (clk_ok),
    .up_on      (conv1_up_path_on),
    .down_on    (conv1_down_path_on),
    .refused    (c1_ref)
  );

  rcc_conv_ctl #(
    .NPATH (C2_PATHS)
  ) u_conv2 (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr         (wr_c2p),
    .up_wdata   (reg_wdata[`RCC_UP_LSB+C2_PATHS-1:`RCC_UP_LSB]),
    .down_wdata (reg_wdata[`RCC_DOWN_LSB+C2_PATHS-1:`RCC_DOWN_LSB]),
    .clk_ok     (clk_ok),
    .up_on      (conv2_up_path_on),
    .down_on    (conv2_down_path_on),
    .refused    (c2_ref)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux; unassigned bits and unmapped addresses read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (reg_rd)
    begin
      case (sel)
        rcc_pkg::RCC_SEL_C1_RATE:
        begin
          rdata_d[`RCC_RATE_HI_MSB:`RCC_RATE_HI_LSB] = c1_lo_q;
          rdata_d[`RCC_RATE_LO_MSB:`RCC_RATE_LO_LSB] = c1_hi_q;
        end
        rcc_pkg::RCC_SEL_C1_PATH:
        begin
          rdata_d[`RCC_UP_LSB+C1_PATHS-1:`RCC_UP_LSB] = conv1_up_path_on;
          rdata_d[`RCC_DOWN_LSB+C1_PATHS-1:`RCC_DOWN_LSB] =
            conv1_down_path_on;
        end
        rcc_pkg::RCC_SEL_C2_RATE:
        begin
          rdata_d[`RCC_RATE_HI_MSB:`RCC_RATE_HI_LSB] = c2_hi_q;
          rdata_d[`RCC_RATE_LO_MSB:`RCC_RATE_LO_LSB] = c2_lo_q;
        end
        rcc_pkg::RCC_SEL_C2_PATH:
        begin
          rdata_d[`RCC_UP_LSB+C2_PATHS-1:`RCC_UP_LSB] = conv2_up_path_on;
          rdata_d[`RCC_DOWN_LSB+C2_PATHS-1:`RCC_DOWN_LSB] =
            conv2_down_path_on;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata       = rdata_q;
  assign conv1_low_rate  = c1_lo_q;
  assign conv1_high_rate = c1_hi_q;
  assign conv2_low_rate  = c2_lo_q;
  assign conv2_high_rate = c2_hi_q;
  assign enable_refused  = c1_ref | c2_ref; // pulse after refused write

endmodule : rcc_bank

/* File: verif/rcc_bank_checker.sv */
// port assertions for the rate converter control bank
// assumes one clock domain and the fixed register layout
`timescale 1ns/1ps
module rcc_bank_checker #(
  parameter int C1_PATHS = 4,
  parameter int C2_PATHS = 2
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [15:0]         reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire logic                clk_ok,
  input wire rcc_pkg::rcc_rate_t  conv1_low_rate,
  input wire rcc_pkg::rcc_rate_t  conv1_high_rate,
  input wire rcc_pkg::rcc_rate_t  conv2_low_rate,
  input wire rcc_pkg::rcc_rate_t  conv2_high_rate,
  input wire logic [C1_PATHS-1:0] conv1_up_path_on,
  input wire logic [C1_PATHS-1:0] conv1_down_path_on,
  input wire logic [C2_PATHS-1:0] conv2_up_path_on,
  input wire logic [C2_PATHS-1:0] conv2_down_path_on,
  input wire logic                enable_refused
);
  logic w1r;
  logic w1p;
  logic w2r;
  logic w2p;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write decode per register
  assign w1r = reg_wr && (reg_addr == 16'ha400);
  assign w1p = reg_wr && (reg_addr == 16'ha404);
  assign w2r = reg_wr && (reg_addr == 16'ha510);
  assign w2p = reg_wr && (reg_addr == 16'ha514);
  AST_C1LO: assert property (
    w1r |=> conv1_low_rate == $past(reg_wdata[31:27])) else $error("c1 lo");
  AST_C1HI: assert property (
    w1r |=> conv1_high_rate == $past(reg_wdata[15:11])) else $error("c1 hi");
  AST_C2HI: assert property (
    w2r |=> conv2_high_rate == $past(reg_wdata[31:27])) else $error("c2 hi");
  AST_C2LO: assert property (
    w2r |=> conv2_low_rate == $past(reg_wdata[15:11])) else $error("c2 lo");
  AST_C1P: assert property (w1p && clk_ok |=>
    {conv1_up_path_on, conv1_down_path_on} ==
    {$past(reg_wdata[11:8]), $past(reg_wdata[3:0])}) else $error("c1 path");
  AST_C2P: assert property (w2p && clk_ok |=>
    {conv2_up_path_on, conv2_down_path_on} ==
    {$past(reg_wdata[9:8]), $past(reg_wdata[1:0])}) else $error("c2 path");
  AST_HOLD: assert property (!reg_wr |=> $stable({conv1_up_path_on,
    conv1_down_path_on, conv2_up_path_on, conv2_down_path_on,
    conv1_low_rate, conv2_high_rate})) else $error("state moved");
  AST_REFUSE: assert property (w1p && !clk_ok &&
    (reg_wdata[11:8] & ~conv1_up_path_on) != 4'h0 |=> enable_refused &&
    (conv1_up_path_on & ~$past(conv1_up_path_on)) == 4'h0)
    else $error("enable not refused");
  AST_RD0: assert property (
    !reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
endmodule : rcc_bank_checker

bind rcc_bank rcc_bank_checker #(.C1_PATHS(C1_PATHS), .C2_PATHS(C2_PATHS))
  u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clk_ok(clk_ok), .conv1_low_rate(conv1_low_rate),
  .conv1_high_rate(conv1_high_rate), .conv2_low_rate(conv2_low_rate),
  .conv2_high_rate(conv2_high_rate), .conv1_up_path_on(conv1_up_path_on),
  .conv1_down_path_on(conv1_down_path_on),
  .conv2_up_path_on(conv2_up_path_on),
  .conv2_down_path_on(conv2_down_path_on),
  .enable_refused(enable_refused));

/* File: verif/rcc_bank_test.sv */
// self-checking bench for the rate converter control bank
// assumes default path counts and a 25 MHz clock
`timescale 1ns/1ps
module rcc_bank_test;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [15:0]        reg_addr = 16'h0;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               clk_ok = 1'b1;
  logic [31:0]        reg_rdata;
  rcc_pkg::rcc_rate_t c1l, c1h, c2l, c2h;
  logic [3:0]         c1u, c1d;
  logic [1:0]         c2u, c2d;
  logic               refused;
  int                 fail_count = 0;
  int                 checked = 0;
  int                 seed = 94598;
  int                 cyc = 0;
  logic [15:0]        adr [5] = '{16'ha400, 16'ha404, 16'ha510, 16'ha514,
                                  16'ha518};
  logic [31:0]        msk [5] = '{32'hf800f800, 32'h00000f0f, 32'hf800f800,
                                  32'h00000303, 32'h0};
  logic [31:0]        m [5];

  rcc_bank uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_ok(clk_ok), .conv1_low_rate(c1l),
    .conv1_high_rate(c1h), .conv2_low_rate(c2l), .conv2_high_rate(c2h),
    .conv1_up_path_on(c1u), .conv1_down_path_on(c1d),
    .conv2_up_path_on(c2u), .conv2_down_path_on(c2d),
    .enable_refused(refused));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles and model
  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task chk_out;
    check("c1 rate", {c1l, 11'h0, c1h, 11'h0}, m[0]);
    check("c1 path", {20'h0, c1u, 4'h0, c1d}, m[1]);
    check("c2 rate", {c2h, 11'h0, c2l, 11'h0}, m[2]);
    check("c2 path", {22'h0, c2u, 6'h0, c2d}, m[3]);
  endtask : chk_out

  // new bits of a path register stay off while the clock is short
  function logic [31:0] nxt(int i, logic [31:0] d, logic ok);
    nxt = d & msk[i] & ((ok || !i[0]) ? 32'hffffffff : m[i]);
  endfunction : nxt

  task wr(input int i, input logic [31:0] d, input logic ok);
    logic e;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= adr[i];
    reg_wdata <= d;
    clk_ok <= ok;
    e = !ok && i[0] && ((d & msk[i] & ~m[i]) != 32'h0);
    m[i] = nxt(i, d, ok);
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 check("refused", {31'h0, refused}, {31'h0, e});
    chk_out();
  endtask : wr

  task rd(input int i);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= adr[i];
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("rdata", reg_rdata, m[i]);
  endtask : rd

  task results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, corners, random traffic, mid-run reset
  initial
  begin
    foreach (m[k]) m[k] = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(i);
    // source selects sit at zero; let 125 us pass before rate writes
    repeat (3125) @(posedge clk);
    wr(1, 32'h00000f01, 1'b1);
    wr(1, 32'hffffffff, 1'b0);
    wr(3, 32'h00000303, 1'b0);
    wr(1, 32'h0, 1'b0);
    wr(0, 32'h18001800, 1'b1);
    for (int n = 0; n < 60; n++)
    begin
      int          i;
      logic [31:0] d;
      i = $unsigned($random(seed)) % 5;
      d = $random(seed);
      if (!i[0]) d = d & 32'h1fff1fff; // codes 0 to 3 only
      // high select never below low select
      if (i == 0 && d[28:27] > d[12:11])
        d = {d[31:29], d[12:11], d[26:13], d[28:27], d[10:0]};
      if (i == 2 && d[12:11] > d[28:27])
        d = {d[31:29], d[12:11], d[26:13], d[28:27], d[10:0]};
      wr(i, d, ($random(seed) % 4) != 0);
      rd(i);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (m[k]) m[k] = 32'h0;
    #1 chk_out();
    for (int i = 0; i < 5; i++) rd(i);
    results();
  end
endmodule : rcc_bank_test
